// ===== inc/i2cp_pkg.sv
// Constants and state types for the serial port in two-wire bus mode
package i2cp_pkg;

  // ----------------------------------------------------------------------
  // Register offsets on the plain register port
  // ----------------------------------------------------------------------
  localparam logic [2:0] OFS_CTRL_PRIMARY = 3'h0;
  localparam logic [2:0] OFS_CTRL_SECONDARY = 3'h1;
  localparam logic [2:0] OFS_PORT_STATUS = 3'h2;
  localparam logic [2:0] OFS_TRANSFER_BUFFER = 3'h3;
  localparam logic [2:0] OFS_ADDRESS_RELOAD = 3'h4;
  localparam logic [2:0] OFS_PORT_IRQ = 3'h5;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTRL_PRIMARY_RST = 8'h00;
  localparam logic [7:0] CTRL_SECONDARY_RST = 8'h00;
  localparam logic [7:0] ADDRESS_RELOAD_RST = 8'h00;
  localparam logic BUS_IDLE_LEVEL = 1'b1;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int C1_WRITE_COLLISION_FLAG = 7;
  localparam int C1_OVF = 6;
  localparam int C1_EN = 5;
  localparam int C1_CKP = 4;
  localparam int C2_GENERAL_CALL_ENABLE = 7;
  localparam int C2_ACKNOWLEDGE_STATUS = 6;
  localparam int C2_ACKNOWLEDGE_VALUE = 5;
  localparam int C2_ACKNOWLEDGE_SEQUENCE_START = 4;
  localparam int C2_MASTER_RECEIVE_ENABLE = 3;
  localparam int C2_PEN = 2;
  localparam int C2_REPEATED_START_REQUEST = 1;
  localparam int C2_SEN = 0;
  localparam int IRQ_FLAG = 0;

  // ----------------------------------------------------------------------
  // Mode codes and bus constants
  // ----------------------------------------------------------------------
  localparam logic [3:0] MODE_SLAVE7 = 4'h6;
  localparam logic [3:0] MODE_SLAVE10 = 4'h7;
  localparam logic [3:0] MODE_MASTER = 4'h8;
  localparam logic [3:0] MODE_FW_MASTER = 4'hb;
  localparam logic [3:0] MODE_SLAVE7_SP = 4'he;
  localparam logic [3:0] MODE_SLAVE10_SP = 4'hf;
  localparam logic [4:0] TEN_BIT_HEADER = 5'h1e;
  localparam logic [7:0] GENERAL_CALL_ADDR = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;

  // ----------------------------------------------------------------------
  // State machines
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ADDR = 3'b001,
    S_RX = 3'b010,
    S_ACK = 3'b011,
    S_TX = 3'b100,
    S_TXACK = 3'b101
  } i2cp_slave_t;

  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_START = 3'b001,
    M_RSTART = 3'b010,
    M_STOP = 3'b011,
    M_TX = 3'b100,
    M_RX = 3'b101,
    M_ACK = 3'b110
  } i2cp_master_t;

endpackage : i2cp_pkg

// ===== rtl/i2cp_port.sv
// Serial port in two-wire bus mode: registers, slave engine, master engine
`timescale 1ns/100ps
module i2cp_port
  import i2cp_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Register port
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Bus pins, open drain
  input wire logic i_scl_in,
  output logic o_scl_out,
  output logic o_scl_oe,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic write_collision_flag, ovf, en, clock_release;
    logic [3:0] mode;
    logic general_call_enable, acknowledge_status, acknowledge_value, acknowledge_sequence_start, master_receive_enable, stop_request, repeated_start_request, start_request_or_stretch_enable;
    logic [7:0] xbuf, sr, addr, rdata;
    logic bf, ua, rw, da, irq, start_seen, stop_seen;
    logic ack, hi_ok, lo_match;
    logic scl_p, sda_p;
    logic [3:0] bitcnt;
    logic [1:0] ph;
    logic [7:0] brg;
    logic m_scl_low, m_sda_low;
    i2cp_slave_t sst;
    i2cp_master_t mst;
  } i2cp_state_t;

  i2cp_state_t q, d;
  logic slave_m, master_m, ten, hdr, gc, mt, tick, master_idle, ld_buf;
  logic scl_rise, scl_fall, start_det, stop_det;

  // ----------------------------------------------------------------------
  // Decodes
  // ----------------------------------------------------------------------
  // Unlisted codes leave both engines idle
  assign slave_m = q.en && (q.mode == MODE_SLAVE7 || q.mode == MODE_SLAVE10 ||
                   q.mode == MODE_SLAVE7_SP ||
                   q.mode == MODE_SLAVE10_SP);
  assign ten = q.mode[0];
  assign master_m = q.en && (q.mode == MODE_MASTER);
  assign master_idle = master_m && q.mst == M_IDLE && !(q.acknowledge_sequence_start || q.master_receive_enable ||
                       q.stop_request || q.repeated_start_request || q.start_request_or_stretch_enable);
  assign scl_rise = i_scl_in && !q.scl_p;
  assign scl_fall = !i_scl_in && q.scl_p;
  assign start_det = q.scl_p && i_scl_in && q.sda_p && !i_sda_in;
  assign stop_det = q.scl_p && i_scl_in && !q.sda_p && i_sda_in;
  assign tick = (q.brg == 8'h00);
  assign hdr = (q.sr[7:3] == TEN_BIT_HEADER) && (q.sr[2:1] == q.addr[2:1]);
  assign gc = q.general_call_enable && (q.sr == GENERAL_CALL_ADDR);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    d = q;
    mt = 1'b0;
    ld_buf = 1'b0;
    d.scl_p = i_scl_in;
    d.sda_p = i_sda_in;
    d.rdata = 8'h00;
    // Register reads, data shown in the next cycle
    if (i_rd) begin
      case (i_addr)
        OFS_CTRL_PRIMARY: d.rdata = {q.write_collision_flag, q.ovf, q.en, q.clock_release, q.mode};
        OFS_CTRL_SECONDARY: d.rdata = {q.general_call_enable, q.acknowledge_status, q.acknowledge_value, q.acknowledge_sequence_start,
                                       q.master_receive_enable, q.stop_request, q.repeated_start_request, q.start_request_or_stretch_enable};
        OFS_PORT_STATUS: d.rdata = {2'b00, q.da, q.stop_seen, q.start_seen,
                                    (master_m ? (q.mst == M_TX) : q.rw),
                                    q.ua, q.bf};
        OFS_TRANSFER_BUFFER: begin
          d.rdata = q.xbuf;
          d.bf = 1'b0;
        end
        OFS_ADDRESS_RELOAD: d.rdata = q.addr;
        OFS_PORT_IRQ: d.rdata = {7'h00, q.irq};
        default: d.rdata = 8'h00;
      endcase
    end
    // Register writes; hardware events below override them
    if (i_wr) begin
      case (i_addr)
        OFS_CTRL_PRIMARY: begin
          d.write_collision_flag = i_wdata[C1_WRITE_COLLISION_FLAG];
          d.ovf = i_wdata[C1_OVF];
          d.en = i_wdata[C1_EN];
          d.clock_release = i_wdata[C1_CKP];
          d.mode = i_wdata[3:0];
        end
        OFS_CTRL_SECONDARY: begin
          d.general_call_enable = i_wdata[C2_GENERAL_CALL_ENABLE];
          d.acknowledge_value = i_wdata[C2_ACKNOWLEDGE_VALUE];
          if (slave_m) begin
            d.start_request_or_stretch_enable = i_wdata[C2_SEN];
          end else if (master_idle) begin
            d.acknowledge_sequence_start = i_wdata[C2_ACKNOWLEDGE_SEQUENCE_START];
            d.master_receive_enable = i_wdata[C2_MASTER_RECEIVE_ENABLE];
            d.stop_request = i_wdata[C2_PEN];
            d.repeated_start_request = i_wdata[C2_REPEATED_START_REQUEST];
            d.start_request_or_stretch_enable = i_wdata[C2_SEN];
          end
        end
        OFS_TRANSFER_BUFFER: begin
          if (master_m) begin
            if (master_idle) begin
              d.xbuf = i_wdata;
              d.sr = i_wdata;
              d.bf = 1'b1;
              d.mst = M_TX;
              d.bitcnt = 4'h0;
            end else begin
              d.write_collision_flag = 1'b1;
            end
          end else if ((q.sst == S_TX && q.bitcnt != 4'h0) ||
                       q.sst == S_TXACK) begin
            d.write_collision_flag = 1'b1;
          end else begin
            d.xbuf = i_wdata;
            d.sr = i_wdata;
            d.bf = 1'b1;
          end
        end
        OFS_ADDRESS_RELOAD: begin
          d.addr = i_wdata;
          d.ua = 1'b0;
        end
        OFS_PORT_IRQ: d.irq = i_wdata[IRQ_FLAG];
        default: ;
      endcase
    end
    // Slave engine
    if (!slave_m) begin
      d.sst = S_IDLE;
      d.hi_ok = 1'b0;
      d.lo_match = 1'b0;
    end else if (stop_det) begin
      d.stop_seen = 1'b1;
      d.start_seen = 1'b0;
      d.sst = S_IDLE;
      d.hi_ok = 1'b0;
      d.lo_match = 1'b0;
      d.rw = 1'b0;
      if (q.mode[3]) begin
        d.irq = 1'b1;
      end
    end else if (start_det) begin
      d.start_seen = 1'b1;
      d.stop_seen = 1'b0;
      d.sst = S_ADDR;
      d.bitcnt = 4'h0;
      d.rw = 1'b0;
      if (q.mode[3]) begin
        d.irq = 1'b1;
      end
    end else begin
      case (q.sst)
        S_ADDR, S_RX: begin
          if (scl_rise && q.bitcnt < BITS_PER_BYTE) begin
            d.sr = {q.sr[6:0], i_sda_in};
            d.bitcnt = q.bitcnt + 4'h1;
          end else if (scl_fall && q.bitcnt == BITS_PER_BYTE) begin
            if (q.sst == S_RX) begin
              mt = 1'b1;
              d.da = 1'b1;
            end else if (!ten) begin
              mt = (q.sr[7:1] == q.addr[7:1]) || gc;
              d.rw = q.sr[0] && !gc;
            end else if (q.hi_ok) begin
              mt = (q.sr == q.addr);
              d.lo_match = mt;
              d.hi_ok = 1'b0;
              d.ua = mt;
            end else if (hdr && !q.sr[0]) begin
              mt = 1'b1;
              d.hi_ok = 1'b1;
              d.ua = 1'b1;
            end else if (hdr && q.lo_match) begin
              mt = 1'b1;
              d.rw = 1'b1;
            end
            if (mt) begin
              d.sst = S_ACK;
              d.bitcnt = 4'h0;
              if (q.sst == S_ADDR) begin
                d.da = 1'b0;
              end
              if (q.bf || q.ovf) begin
                d.ack = 1'b0;
                d.ovf = 1'b1;
              end else begin
                d.ack = 1'b1;
                d.xbuf = q.sr;
                d.bf = 1'b1;
                ld_buf = 1'b1;
              end
            end else begin
              d.sst = S_IDLE;
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            d.ack = 1'b0;
            d.irq = 1'b1;
            d.bitcnt = 4'h0;
            if (q.rw) begin
              d.clock_release = 1'b0; // Transmit always stretches to load data
              d.sst = S_TX;
            end else begin
              // Ten-bit address bytes stretch only through the update flag
              if (q.start_request_or_stretch_enable && q.bf && !(ten && !q.da)) begin
                d.clock_release = 1'b0;
              end
              d.sst = q.hi_ok ? S_ADDR : S_RX;
            end
          end
        end
        S_TX: begin
          if (scl_fall) begin
            d.sr = {q.sr[6:0], 1'b1};
            d.bitcnt = q.bitcnt + 4'h1;
            if (q.bitcnt == LAST_DATA_BIT) begin
              d.sst = S_TXACK;
              d.bf = 1'b0;
            end
          end
        end
        S_TXACK: begin
          if (scl_rise && i_sda_in) begin
            d.sst = S_IDLE; // Not acknowledged: transfer over
            d.rw = 1'b0;
          end else if (scl_fall) begin
            d.irq = 1'b1;
            d.clock_release = 1'b0;
            d.bitcnt = 4'h0;
            d.sst = S_TX;
          end
        end
        default: d.sst = S_IDLE;
      endcase
    end
    // Master engine, one step per quarter bit time
    if (!master_m) begin
      d.mst = M_IDLE;
      d.m_scl_low = 1'b0;
      d.m_sda_low = 1'b0;
    end else if (q.mst == M_IDLE) begin
      d.brg = q.addr;
      d.ph = 2'b00;
      d.bitcnt = (q.master_receive_enable || q.acknowledge_sequence_start) ? 4'h0 : d.bitcnt;
      if (q.start_request_or_stretch_enable) begin
        d.mst = M_START;
      end else if (q.repeated_start_request) begin
        d.mst = M_RSTART;
      end else if (q.stop_request) begin
        d.mst = M_STOP;
      end else if (q.master_receive_enable) begin
        d.mst = M_RX;
      end else if (q.acknowledge_sequence_start) begin
        d.mst = M_ACK;
      end
    end else if (!tick) begin
      d.brg = q.brg - 8'h01;
    end else begin
      d.brg = q.addr;
      d.ph = q.ph + 2'b01;
      case (q.mst)
        M_START: begin
          case (q.ph)
            2'b00: d.m_sda_low = 1'b0;
            2'b01: d.m_sda_low = 1'b1;
            default: begin
              d.m_scl_low = 1'b1;
              d.start_request_or_stretch_enable = 1'b0;
              d.irq = 1'b1;
              d.mst = M_IDLE;
            end
          endcase
        end
        M_RSTART: begin
          case (q.ph)
            2'b00: d.m_sda_low = 1'b0;
            2'b01: d.m_scl_low = 1'b0;
            2'b10: d.m_sda_low = 1'b1;
            default: begin
              d.m_scl_low = 1'b1;
              d.repeated_start_request = 1'b0;
              d.irq = 1'b1;
              d.mst = M_IDLE;
            end
          endcase
        end
        M_STOP: begin
          case (q.ph)
            2'b00: d.m_sda_low = 1'b1;
            2'b01: d.m_scl_low = 1'b0;
            2'b10: d.m_sda_low = 1'b0;
            default: begin
              d.stop_request = 1'b0;
              d.irq = 1'b1;
              d.mst = M_IDLE;
            end
          endcase
        end
        M_TX, M_RX, M_ACK: begin
          case (q.ph)
            2'b00: begin
              d.m_scl_low = 1'b1;
              if (q.mst == M_TX) begin
                d.m_sda_low = (q.bitcnt < BITS_PER_BYTE) && !q.sr[7];
              end else begin
                d.m_sda_low = (q.mst == M_ACK) && !q.acknowledge_value;
              end
            end
            2'b01: d.m_scl_low = 1'b0;
            2'b10: begin
              if (q.mst == M_TX && q.bitcnt == BITS_PER_BYTE) begin
                d.acknowledge_status = i_sda_in;
              end else if (q.mst == M_RX) begin
                d.sr = {q.sr[6:0], i_sda_in};
              end
            end
            default: begin
              d.m_scl_low = 1'b1;
              d.bitcnt = q.bitcnt + 4'h1;
              if (q.mst == M_TX) begin
                d.sr = {q.sr[6:0], 1'b1};
                if (q.bitcnt == BITS_PER_BYTE) begin
                  d.bf = 1'b0;
                  d.irq = 1'b1;
                  d.m_sda_low = 1'b0;
                  d.mst = M_IDLE;
                end
              end else if (q.mst == M_RX) begin
                if (q.bitcnt == LAST_DATA_BIT) begin
                  if (q.bf) begin
                    d.ovf = 1'b1;
                  end else begin
                    d.xbuf = q.sr;
                    d.bf = 1'b1;
                    ld_buf = 1'b1;
                  end
                  d.master_receive_enable = 1'b0;
                  d.irq = 1'b1;
                  d.mst = M_IDLE;
                end
              end else begin
                d.acknowledge_sequence_start = 1'b0;
                d.irq = 1'b1;
                d.m_sda_low = 1'b0;
                d.mst = M_IDLE;
              end
            end
          endcase
        end
        default: d.mst = M_IDLE;
      endcase
    end
    // Disabled port forgets bus history
    if (!q.en) begin
      d.start_seen = 1'b0;
      d.stop_seen = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      q <= '0;
      {q.write_collision_flag, q.ovf, q.en, q.clock_release, q.mode} <= CTRL_PRIMARY_RST;
      {q.general_call_enable, q.acknowledge_status, q.acknowledge_value, q.acknowledge_sequence_start, q.master_receive_enable, q.stop_request, q.repeated_start_request,
       q.start_request_or_stretch_enable} <= CTRL_SECONDARY_RST;
      q.addr <= ADDRESS_RELOAD_RST;
      q.sst <= S_IDLE;
      q.mst <= M_IDLE;
      // Idle pin history, so no false edge follows reset
      q.scl_p <= BUS_IDLE_LEVEL;
      q.sda_p <= BUS_IDLE_LEVEL;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Open drain: only ever pull low, and only while the port owns the pins
  assign o_scl_out = 1'b0;
  assign o_sda_out = 1'b0;
  // Update hold starts after the ninth clock so the ack still goes out
  assign o_scl_oe = (slave_m && (!q.clock_release || (q.ua && q.sst != S_ACK))) ||
                    (master_m && q.m_scl_low);
  assign o_sda_oe = (slave_m && ((q.sst == S_ACK && q.ack) ||
                    (q.sst == S_TX && !q.sr[7]))) ||
                    (master_m && q.m_sda_low);
  assign o_rdata = q.rdata;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_PINS_RELEASED: assert property (@(posedge i_ref_clk)
    disable iff (i_sys_rst) !q.en |-> !o_scl_oe && !o_sda_oe)
    else $error("Pins driven while port disabled");

  AST_CLOCK_HOLD: assert property (@(posedge i_ref_clk)
    disable iff (i_sys_rst) slave_m && !q.clock_release |-> o_scl_oe)
    else $error("Slave clock release low but SCL not held");

  AST_MASTER_COLLISION: assert property (@(posedge i_ref_clk)
    disable iff (i_sys_rst)
    master_m && !master_idle && i_wr && i_addr == OFS_TRANSFER_BUFFER
    |=> q.write_collision_flag && $stable(q.xbuf))
    else $error("Busy master buffer write not flagged");

  AST_REQUEST_IGNORED: assert property (@(posedge i_ref_clk)
    disable iff (i_sys_rst)
    master_m && !master_idle && !q.stop_request && i_wr &&
    i_addr == OFS_CTRL_SECONDARY && i_wdata[C2_PEN] |=> !q.stop_request)
    else $error("Stop request accepted while busy");

  AST_START_SEQUENCE: assert property (@(posedge i_ref_clk)
    disable iff (i_sys_rst)
    master_m && q.mst == M_IDLE && q.start_request_or_stretch_enable |=> q.mst == M_START)
    else $error("Start request did not start sequence");

  AST_STOP_CLEARED: assert property (@(posedge i_ref_clk)
    disable iff (i_sys_rst)
    master_m && $fell(q.stop_request) |-> $past(q.mst) == M_STOP && q.irq)
    else $error("Stop request cleared outside stop sequence");

  AST_BUFFER_READ: assert property (@(posedge i_ref_clk)
    disable iff (i_sys_rst)
    i_rd && i_addr == OFS_TRANSFER_BUFFER && !ld_buf &&
    !(i_wr) |=> !q.bf)
    else $error("Buffer read did not clear buffer full");

  AST_REFUSED_NO_ACK: assert property (@(posedge i_ref_clk)
    disable iff (i_sys_rst)
    slave_m && scl_fall && q.bitcnt == BITS_PER_BYTE && (q.bf || q.ovf) &&
    (q.sst == S_ADDR || q.sst == S_RX) && !i_wr
    |=> !o_sda_oe && $stable(q.xbuf))
    else $error("Refused byte was acknowledged or loaded");

  AST_UPDATE_HOLD: assert property (@(posedge i_ref_clk)
    disable iff (i_sys_rst) slave_m && q.ua && q.sst != S_ACK |-> o_scl_oe)
    else $error("Address update pending but SCL released");

endmodule : i2cp_port

// ===== verification/i2c_master_slave_port_test.sv
// Self-checking bench for the two-wire serial port
`timescale 1ns/100ps
module i2c_master_slave_port_test;
  import i2cp_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata;
  logic o_scl_oe, o_sda_oe, m_scl_oe, m_sda_oe, nack;
  logic [7:0] v, dat, tmp;
  logic [6:0] own;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int seed;
  // Pull-ups: a wire is low if any party pulls it
  wire scl = ~(o_scl_oe | m_scl_oe);
  wire sda = ~(o_sda_oe | m_sda_oe);
  always #20 i_ref_clk = ~i_ref_clk;
  i2cp_port u_dut (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_scl_in(scl), .o_scl_out(), .o_scl_oe(o_scl_oe),
    .i_sda_in(sda), .o_sda_out(), .o_sda_oe(o_sda_oe));
  i2cp_bus_master_model u_mst (.i_ref_clk(i_ref_clk), .i_scl(scl),
    .i_sda(sda), .o_scl_oe(m_scl_oe), .o_sda_oe(m_sda_oe));
  // ---------------------------------------------------------------
  // Bus tasks and comparison
  // ---------------------------------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    // One edge between calls, so the strobe is never set twice at once
    @(posedge i_ref_clk);
  endtask : wr
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    @(posedge i_ref_clk);
    d = o_rdata;
  endtask : rd
  task automatic check(input string n, input logic [7:0] s, e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : check
  // Poll a self-clearing request bit under a bound
  task automatic wait_clear(input int b);
    int n;
    n = 0;
    rd(OFS_CTRL_SECONDARY, v);
    while (v[b] !== 1'b0 && n < 200) begin
      rd(OFS_CTRL_SECONDARY, v);
      n++;
    end
    check("request", {7'h0, v[b]}, 8'h00);
  endtask : wait_clear
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  // Hang guard
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      stop_test();
    end
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    seed = 20672;
    repeat (2) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_ref_clk);
    rd(OFS_CTRL_PRIMARY, v);
    check("ctrl1", v, CTRL_PRIMARY_RST);
    rd(OFS_CTRL_SECONDARY, v);
    check("ctrl2", v, CTRL_SECONDARY_RST);
    wr(3'h6, 8'hff);
    rd(3'h6, v);
    check("unmapped", v, 8'h00);
    tmp = 8'($random(seed));
    own = {1'b1, tmp[5:0]}; // Never the general call address
    dat = 8'($random(seed));
    wr(OFS_ADDRESS_RELOAD, {own, 1'b0});
    wr(OFS_CTRL_PRIMARY, 8'h36);
    // Address taken, then a byte while the buffer is still full
    u_mst.start();
    u_mst.put_byte({own, 1'b0}, nack);
    check("addr_ack", {7'h0, nack}, 8'h00);
    rd(OFS_PORT_IRQ, v);
    check("irq", {7'h0, v[IRQ_FLAG]}, 8'h01);
    u_mst.put_byte(dat, nack);
    check("full_nack", {7'h0, nack}, 8'h01);
    rd(OFS_CTRL_PRIMARY, v);
    check("ovf", {7'h0, v[C1_OVF]}, 8'h01);
    rd(OFS_TRANSFER_BUFFER, v);
    check("buffer", v, {own, 1'b0});
    rd(OFS_PORT_STATUS, v);
    check("full", {7'h0, v[0]}, 8'h00);
    rd(OFS_CTRL_PRIMARY, v);
    check("ovf_kept", {7'h0, v[C1_OVF]}, 8'h01);
    u_mst.stop();
    wr(OFS_CTRL_PRIMARY, 8'h36);
    wr(OFS_PORT_IRQ, 8'h00);
    // Foreign address is refused
    u_mst.start();
    u_mst.put_byte({own ^ 7'h01, 1'b0}, nack);
    check("foreign", {7'h0, nack}, 8'h01);
    rd(OFS_PORT_IRQ, v);
    check("no_irq", {7'h0, v[IRQ_FLAG]}, 8'h00);
    u_mst.stop();
    // General call taken while enabled
    wr(OFS_CTRL_SECONDARY, 8'h80);
    u_mst.start();
    u_mst.put_byte(GENERAL_CALL_ADDR, nack);
    check("gcall", {7'h0, nack}, 8'h00);
    rd(OFS_TRANSFER_BUFFER, v);
    check("gc_buf", v, GENERAL_CALL_ADDR);
    u_mst.stop();
    // Address then data with stretching and the buffer emptied between
    wr(OFS_CTRL_SECONDARY, 8'h01);
    u_mst.start();
    u_mst.put_byte({own, 1'b0}, nack);
    rd(OFS_CTRL_PRIMARY, v);
    check("stretch", {7'h0, v[C1_CKP]}, 8'h00);
    rd(OFS_TRANSFER_BUFFER, v);
    wr(OFS_CTRL_PRIMARY, 8'h36);
    u_mst.put_byte(dat, nack);
    check("data_ack", {7'h0, nack}, 8'h00);
    rd(OFS_TRANSFER_BUFFER, v);
    check("data", v, dat);
    wr(OFS_CTRL_PRIMARY, 8'h36);
    u_mst.stop();
    // Ten-bit header: acknowledged, then SCL held until the reload
    wr(OFS_ADDRESS_RELOAD, tmp);
    wr(OFS_CTRL_PRIMARY, 8'h37);
    u_mst.start();
    u_mst.put_byte({TEN_BIT_HEADER, tmp[2:1], 1'b0}, nack);
    check("hdr_ack", {7'h0, nack}, 8'h00);
    rd(OFS_PORT_STATUS, v);
    check("update", {6'h0, o_scl_oe, v[1]}, 8'h03);
    wr(OFS_ADDRESS_RELOAD, tmp);
    check("reload", {7'h0, o_scl_oe}, 8'h00);
    u_mst.stop();
    // Clock hold and port release
    wr(OFS_CTRL_PRIMARY, 8'h26);
    @(posedge i_ref_clk);
    check("hold", {7'h0, o_scl_oe}, 8'h01);
    wr(OFS_CTRL_PRIMARY, 8'h36);
    @(posedge i_ref_clk);
    check("release", {7'h0, o_scl_oe}, 8'h00);
    wr(OFS_CTRL_PRIMARY, 8'h00);
    @(posedge i_ref_clk);
    check("pins", {6'h0, o_scl_oe, o_sda_oe}, 8'h00);
    // Hardware master: start with a colliding buffer write, then a stop request that is refused
    wr(OFS_ADDRESS_RELOAD, 8'h01);
    wr(OFS_CTRL_PRIMARY, 8'h28);
    wr(OFS_CTRL_SECONDARY, 8'h01);
    wr(OFS_TRANSFER_BUFFER, 8'h5a);
    wr(OFS_CTRL_SECONDARY, 8'h04); // Stop asked while start still runs
    rd(OFS_CTRL_PRIMARY, v);
    check("write_collision_flag", {7'h0, v[C1_WRITE_COLLISION_FLAG]}, 8'h01);
    wait_clear(C2_SEN);
    check("busy_stop", {7'h0, v[C2_PEN]}, 8'h00);
    // Byte out with no slave on the bus: acknowledge missing
    wr(OFS_TRANSFER_BUFFER, dat);
    rd(OFS_PORT_STATUS, v);
    while (v[0] === 1'b1) rd(OFS_PORT_STATUS, v);
    rd(OFS_CTRL_SECONDARY, v);
    check("acknowledge_status", {7'h0, v[C2_ACKNOWLEDGE_STATUS]}, 8'h01);
    // Byte in from the released SDA, acknowledge, repeated start, stop
    wr(OFS_CTRL_SECONDARY, 8'h08);
    wait_clear(C2_MASTER_RECEIVE_ENABLE);
    rd(OFS_TRANSFER_BUFFER, v);
    check("rx_byte", v, 8'hff);
    wr(OFS_CTRL_SECONDARY, 8'h10);
    wait_clear(C2_ACKNOWLEDGE_SEQUENCE_START);
    wr(OFS_CTRL_SECONDARY, 8'h02);
    wait_clear(C2_REPEATED_START_REQUEST);
    wr(OFS_CTRL_SECONDARY, 8'h04);
    wait_clear(C2_PEN);
    stop_test();
  end
endmodule : i2c_master_slave_port_test

// ===== verification/i2cp_bus_master_model.sv
// Behavioural bus master that frames transfers toward the port
`timescale 1ns/100ps
module i2cp_bus_master_model #(
  parameter int QTR = 4
) (
  // Clock
  input wire logic i_ref_clk,
  // Resolved wires
  input wire logic i_scl,
  input wire logic i_sda,
  // Pull-down enables
  output logic o_scl_oe,
  output logic o_sda_oe
);
  initial begin
    o_scl_oe = 1'b0;
    o_sda_oe = 1'b0;
  end
  // Quarter bit in system clocks
  task automatic qwait();
    repeat (QTR) @(posedge i_ref_clk);
  endtask : qwait
  // Release SCL; bounded so a stuck slave cannot hang the run
  task automatic scl_up();
    int n;
    n = 0;
    o_scl_oe <= 1'b0;
    @(posedge i_ref_clk);
    while (!i_scl && n < 4000) begin
      @(posedge i_ref_clk);
      n++;
    end
  endtask : scl_up
  // Start: SDA falls while SCL high
  task automatic start();
    o_sda_oe <= 1'b0;
    scl_up();
    qwait();
    o_sda_oe <= 1'b1;
    qwait();
    o_scl_oe <= 1'b1;
    qwait();
  endtask : start
  // Stop: SDA rises while SCL high, wires left to the pull-ups
  task automatic stop();
    o_sda_oe <= 1'b1;
    qwait();
    scl_up();
    qwait();
    o_sda_oe <= 1'b0;
    qwait();
  endtask : stop
  // One bit, SCL low on entry and exit; data change only while low
  task automatic bit_io(input logic b, output logic s);
    o_sda_oe <= ~b;
    qwait();
    scl_up();
    qwait();
    s = i_sda;
    o_scl_oe <= 1'b1;
    qwait();
  endtask : bit_io
  // Byte most significant bit first, ninth clock with SDA released
  task automatic put_byte(input logic [7:0] d, output logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, nack);
  endtask : put_byte
endmodule : i2cp_bus_master_model
